/* File: common/adcs_pkg.sv */
package adcs_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_DATA_LO = 8'h78;
	localparam logic [7:0] IDX_DATA_HI = 8'h79;
	localparam logic [7:0] IDX_CTRL = 8'h7A;
	localparam logic [7:0] IDX_TRIG = 8'h7B;
	localparam logic [7:0] IDX_INSEL = 8'h7C;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EN = 7;
	localparam int CTRL_START = 6;
	localparam int CTRL_AUTO = 5;
	localparam int CTRL_FLAG = 4;
	localparam int CTRL_IE = 3;
	localparam int INSEL_ALIGN = 5;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] INSEL_RST = 8'h00;
	localparam logic [2:0] TRIG_RST = 3'h0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] REF_EXT_PIN = 2'h0;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	localparam logic [1:0] REF_1V1 = 2'h2;
	localparam logic [1:0] REF_2V56 = 2'h3;
	localparam logic [1:0] GAIN_1X = 2'h0;
	localparam logic [1:0] GAIN_10X = 2'h1;
	localparam logic [1:0] GAIN_200X = 2'h2;
	localparam logic [4:0] CH_BANDGAP = 5'h1E;
	localparam logic [4:0] CH_GROUND = 5'h1F;
	localparam logic [2:0] TRIG_FREE = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Conversion timing in converter clock cycles
	// ----------------------------------------------------------------
	localparam logic [4:0] FIRST_CYC = 5'h19;
	localparam logic [4:0] NORM_CYC = 5'h0D;
	localparam logic [4:0] SAMPLE_FIRST = 5'h0D;
	localparam logic [4:0] SAMPLE_NORM = 5'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01
	} adcs_state_type;

	// Division factor of the converter clock
	function automatic logic [7:0] div_factor(input logic [2:0] c);
		return (c == 3'h0) ? 8'h02 : (8'h01 << c);
	endfunction

endpackage

/* File: common/adcs_presc_if.sv */
`timescale 1ns/1ps
interface adcs_presc_if;
	logic run;
	logic [2:0] div;
	logic tick;
	modport ctl (output run, output div, input tick);
	modport gen (input run, input div, output tick);
endinterface

/* File: rtl/adcs_prescaler.sv */
`timescale 1ns/1ps
module adcs_prescaler (
	input wire logic ref_clk,
	input wire logic resetn,
	adcs_presc_if.gen pif
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic tick_q;
	logic tick_d;

	// One tick every div_factor cycles, held at zero while stopped
	always_comb begin
		cnt_d = 8'h00;
		tick_d = 1'b0;
		if (pif.run) begin
			if (cnt_q >= adcs_pkg::div_factor(pif.div) - 8'h01) begin
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign pif.tick = tick_q;
endmodule

/* File: rtl/adcs_sync.sv */
`timescale 1ns/1ps
module adcs_sync #(
	parameter int WIDTH = 7
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	if (WIDTH < 1) begin : gChk
		$error("WIDTH must be at least 1");
	end

	// A change counts once the second and third stage agree
	always_comb begin
		out_d = (out_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule

/* File: rtl/adcs_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module adcs_top #(
	parameter int ADDR_W = 12
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic globalIrqEn,
	input wire logic vectorAck,
	input wire logic [6:0] trigSrc,
	input wire logic [9:0] coreResult,
	output logic [3:0] refSelect,
	output logic [2:0] muxPos,
	output logic [1:0] muxNeg,
	output logic [1:0] gainSel,
	output logic diffMode,
	output logic bandgapSel,
	output logic groundSel,
	output logic sampleStrobe,
	output logic convIrq
);
	if (ADDR_W < 10) begin : gChk
		$error("ADDR_W must be at least 10");
	end

	typedef struct packed {
		logic awHave;
		logic [ADDR_W-1:0] awAddr;
		logic wHave;
		logic [7:0] wData;
		logic wStrb0;
		logic awRdy;
		logic wRdy;
		logic bValid;
		logic [1:0] bResp;
		logic arRdy;
		logic rValid;
		logic [7:0] rData;
		logic [1:0] rResp;
		logic en;
		logic auto;
		logic ie;
		logic [2:0] div;
		logic flag;
		logic [2:0] trigSel;
		logic [7:0] inSel;
		logic first;
		logic convFirst;
		adcs_pkg::adcs_state_type st;
		logic [4:0] cnt;
		logic [9:0] result;
		logic lock;
		logic trigPrev;
		logic [6:0] act;
		logic [3:0] refSel;
		logic [2:0] pos;
		logic [1:0] neg;
		logic [1:0] gain;
		logic diff;
		logic bg;
		logic gnd;
		logic sample;
		logic irq;
		logic [7:0] gap;
		logic gapValid;
	} adcs_regs_type;

	adcs_regs_type s_q;
	adcs_regs_type s_d;
	logic [6:0] trigSync;
	logic wrFire;
	logic wrEn;
	logic ctrlWr;
	logic startWr;
	logic rdFire;
	logic rdLo;
	logic rdHi;
	logic [7:0] rd;
	logic [7:0] wd;
	logic trigLvl;
	logic trigEdge;
	logic enRise;
	logic finish;
	logic [4:0] lastCnt;
	logic [4:0] sampleAt;
	logic [4:0] m;

	adcs_presc_if pif ();

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	adcs_sync #(
		.WIDTH(7)
	) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.din(trigSrc),
		.dout(trigSync)
	);

	adcs_prescaler u_presc (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pif(pif.gen)
	);

	assign pif.run = s_q.en;
	assign pif.div = s_q.div;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [7:0] i);
		return a[ADDR_W-1:2] == (ADDR_W-2)'(i);
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, adcs_pkg::IDX_DATA_LO) || hit(a, adcs_pkg::IDX_DATA_HI)
			|| hit(a, adcs_pkg::IDX_CTRL) || hit(a, adcs_pkg::IDX_TRIG)
			|| hit(a, adcs_pkg::IDX_INSEL);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sample = 1'b0;
		finish = 1'b0;
		// Write channels, taken in either order
		if (s_axi_awvalid && s_q.awRdy) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wRdy) begin
			s_d.wHave = 1'b1;
			s_d.wData = s_axi_wdata[7:0];
			s_d.wStrb0 = s_axi_wstrb[0];
		end
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid = 1'b0;
		end
		wrFire = s_q.awHave && s_q.wHave && !s_q.bValid;
		wrEn = wrFire && s_q.wStrb0;
		wd = s_q.wData;
		if (wrFire) begin
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp = mapped(s_q.awAddr) ? adcs_pkg::RESP_OKAY
				: adcs_pkg::RESP_SLVERR;
		end
		ctrlWr = wrEn && hit(s_q.awAddr, adcs_pkg::IDX_CTRL);
		startWr = ctrlWr && wd[adcs_pkg::CTRL_START];
		if (wrEn && hit(s_q.awAddr, adcs_pkg::IDX_TRIG)) begin
			s_d.trigSel = wd[2:0];
		end
		if (wrEn && hit(s_q.awAddr, adcs_pkg::IDX_INSEL)) begin
			s_d.inSel = wd;
		end
		if (ctrlWr) begin
			s_d.en = wd[adcs_pkg::CTRL_EN];
			s_d.auto = wd[adcs_pkg::CTRL_AUTO];
			s_d.ie = wd[adcs_pkg::CTRL_IE];
			s_d.div = wd[2:0];
		end
		// Read channel, data bytes follow the current alignment
		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid = 1'b0;
		end
		rdFire = s_axi_arvalid && s_q.arRdy;
		rdLo = rdFire && hit(s_axi_araddr, adcs_pkg::IDX_DATA_LO);
		rdHi = rdFire && hit(s_axi_araddr, adcs_pkg::IDX_DATA_HI);
		rd = 8'h00;
		if (hit(s_axi_araddr, adcs_pkg::IDX_DATA_LO)) begin
			rd = s_q.inSel[adcs_pkg::INSEL_ALIGN]
				? {s_q.result[1:0], 6'h00} : s_q.result[7:0];
		end else if (hit(s_axi_araddr, adcs_pkg::IDX_DATA_HI)) begin
			rd = s_q.inSel[adcs_pkg::INSEL_ALIGN]
				? s_q.result[9:2] : {6'h00, s_q.result[9:8]};
		end else if (hit(s_axi_araddr, adcs_pkg::IDX_CTRL)) begin
			rd = {s_q.en, s_q.st == adcs_pkg::ST_CONV, s_q.auto,
				s_q.flag, s_q.ie, s_q.div};
		end else if (hit(s_axi_araddr, adcs_pkg::IDX_TRIG)) begin
			rd = {5'h00, s_q.trigSel};
		end else if (hit(s_axi_araddr, adcs_pkg::IDX_INSEL)) begin
			rd = s_q.inSel;
		end
		if (rdFire) begin
			s_d.rValid = 1'b1;
			s_d.rData = rd;
			s_d.rResp = mapped(s_axi_araddr) ? adcs_pkg::RESP_OKAY
				: adcs_pkg::RESP_SLVERR;
		end
		if (rdLo) begin
			s_d.lock = 1'b1;
		end
		if (rdHi) begin
			s_d.lock = 1'b0;
		end
		s_d.awRdy = !s_d.awHave && !s_d.bValid;
		s_d.wRdy = !s_d.wHave && !s_d.bValid;
		s_d.arRdy = !s_d.rValid;
		// Trigger source and its rising edge
		trigLvl = (s_q.trigSel == adcs_pkg::TRIG_FREE) ? 1'b0
			: trigSync[3'(s_q.trigSel - 3'h1)];
		trigEdge = trigLvl && !s_q.trigPrev;
		s_d.trigPrev = trigLvl;
		enRise = s_d.en && !s_q.en;
		if (enRise) begin
			s_d.first = 1'b1;
		end
		lastCnt = s_q.convFirst ? adcs_pkg::FIRST_CYC - 5'h01
			: adcs_pkg::NORM_CYC - 5'h01;
		sampleAt = s_q.convFirst ? adcs_pkg::SAMPLE_FIRST
			: adcs_pkg::SAMPLE_NORM;
		// Conversion sequencer
		case (s_q.st)
			adcs_pkg::ST_IDLE: begin
				s_d.act = {s_d.inSel[7:6], s_d.inSel[4:0]};
				if (s_d.en && (startWr || (s_q.auto && trigEdge))) begin
					s_d.st = adcs_pkg::ST_CONV;
					s_d.cnt = 5'h00;
					s_d.convFirst = s_q.first || enRise;
					s_d.first = 1'b0;
				end
			end
			adcs_pkg::ST_CONV: begin
				if (!s_d.en) begin
					s_d.st = adcs_pkg::ST_IDLE;
				end else if (pif.tick) begin
					s_d.sample = (s_q.cnt == sampleAt);
					if (s_q.cnt == lastCnt) begin
						finish = 1'b1;
						if (!s_q.lock) begin
							s_d.result = coreResult;
						end
						s_d.act = {s_q.inSel[7:6], s_q.inSel[4:0]};
						if (s_q.auto && s_q.trigSel == adcs_pkg::TRIG_FREE) begin
							s_d.cnt = 5'h00;
							s_d.convFirst = 1'b0;
						end else begin
							s_d.st = adcs_pkg::ST_IDLE;
						end
					end else begin
						s_d.cnt = s_q.cnt + 5'h01;
					end
				end
			end
			default: begin
				s_d.st = adcs_pkg::ST_IDLE;
			end
		endcase
		// Done flag, set wins over clear
		if (vectorAck || (ctrlWr && wd[adcs_pkg::CTRL_FLAG])) begin
			s_d.flag = 1'b0;
		end
		if (finish) begin
			s_d.flag = 1'b1;
		end
		s_d.irq = s_q.flag && s_q.ie && globalIrqEn;
		// Selects towards the analog core
		s_d.refSel = 4'h1 << s_q.act[6:5];
		m = s_q.act[4:0];
		s_d.pos = m[2:0];
		s_d.neg = 2'h0;
		s_d.gain = adcs_pkg::GAIN_1X;
		s_d.diff = 1'b0;
		s_d.bg = 1'b0;
		s_d.gnd = 1'b0;
		case (m[4:3])
			2'b00: begin
				s_d.diff = 1'b0;
			end
			2'b01: begin
				s_d.diff = 1'b1;
				s_d.pos = {1'b0, m[2], m[0]};
				s_d.neg = m[2] ? 2'h2 : 2'h0;
				s_d.gain = m[1] ? adcs_pkg::GAIN_200X : adcs_pkg::GAIN_10X;
			end
			2'b10: begin
				s_d.diff = 1'b1;
				s_d.neg = 2'h1;
			end
			default: begin
				if (m == adcs_pkg::CH_BANDGAP) begin
					s_d.bg = 1'b1;
				end else if (m == adcs_pkg::CH_GROUND) begin
					s_d.gnd = 1'b1;
				end else begin
					s_d.diff = 1'b1;
					s_d.neg = 2'h2;
				end
			end
		endcase
		// Prescaler period watch
		if (!s_q.en || s_d.div != s_q.div) begin
			s_d.gap = 8'h00;
			s_d.gapValid = 1'b0;
		end else if (pif.tick) begin
			s_d.gap = 8'h00;
			s_d.gapValid = 1'b1;
		end else begin
			s_d.gap = s_q.gap + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.inSel <= adcs_pkg::INSEL_RST;
			s_q.trigSel <= adcs_pkg::TRIG_RST;
			s_q.div <= adcs_pkg::CTRL_RST[2:0];
			s_q.refSel <= 4'h1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = s_q.awRdy;
	assign s_axi_wready = s_q.wRdy;
	assign s_axi_bvalid = s_q.bValid;
	assign s_axi_bresp = s_q.bResp;
	assign s_axi_arready = s_q.arRdy;
	assign s_axi_rvalid = s_q.rValid;
	assign s_axi_rdata = {24'h000000, s_q.rData};
	assign s_axi_rresp = s_q.rResp;
	assign refSelect = s_q.refSel;
	assign muxPos = s_q.pos;
	assign muxNeg = s_q.neg;
	assign gainSel = s_q.gain;
	assign diffMode = s_q.diff;
	assign bandgapSel = s_q.bg;
	assign groundSel = s_q.gnd;
	assign sampleStrobe = s_q.sample;
	assign convIrq = s_q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	AST_SEL_HOLD: assert property (
		s_q.st == adcs_pkg::ST_CONV && $past(s_q.st) == adcs_pkg::ST_CONV
		&& !$past(finish) |-> $stable(s_q.act))
		else $error("selection changed during conversion");
	AST_ALIGN_LO: assert property (
		rdLo && s_q.inSel[adcs_pkg::INSEL_ALIGN]
		|=> s_q.rData == {$past(s_q.result[1:0]), 6'h00})
		else $error("left aligned low byte wrong");
	AST_EN_GATE: assert property (
		s_q.st == adcs_pkg::ST_CONV |-> s_q.en)
		else $error("conversion running while disabled");
	AST_CONV_LEN: assert property (
		finish |-> s_q.cnt == (s_q.convFirst ? 5'h18 : 5'h0C))
		else $error("conversion length wrong");
	AST_BUSY_READ: assert property (
		rdFire && hit(s_axi_araddr, adcs_pkg::IDX_CTRL)
		&& s_q.st == adcs_pkg::ST_CONV |=> s_q.rData[6])
		else $error("start bit not reading one while busy");
	AST_FLAG_SET: assert property (
		finish && !s_q.lock |=> s_q.flag && s_q.result == $past(coreResult))
		else $error("completion did not update result and flag");
	AST_IRQ: assert property (
		s_q.flag && s_q.ie && globalIrqEn |=> convIrq ##1 1'b1)
		else $error("interrupt request missing");
	AST_FLAG_CLR: assert property (
		vectorAck && !finish |=> !s_q.flag)
		else $error("flag not cleared by vector entry");
	AST_DIV: assert property (
		pif.tick && s_q.gapValid
		|-> s_q.gap + 8'h01 == adcs_pkg::div_factor(s_q.div))
		else $error("converter clock period wrong");
	AST_FREE_NOTRIG: assert property (
		s_q.st == adcs_pkg::ST_IDLE && s_q.trigSel == adcs_pkg::TRIG_FREE
		&& !startWr |=> s_q.st == adcs_pkg::ST_IDLE)
		else $error("free running started without start write");
	AST_LOCK: assert property (
		s_q.lock |=> $stable(s_q.result))
		else $error("result changed while locked");
	AST_RUN_GATE: assert property (
		!s_q.en |=> !pif.tick)
		else $error("prescaler ticking while disabled");

	COV_FIRST: cover property (finish && s_q.convFirst);
	COV_FREE: cover property (finish && s_q.auto
		&& s_q.trigSel == adcs_pkg::TRIG_FREE);
	COV_TRIG: cover property (s_q.auto && trigEdge
		&& s_q.st == adcs_pkg::ST_IDLE && s_q.en);
	COV_LOCK: cover property (finish && s_q.lock);
endmodule

/* File: testbench/adcs_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Analog core model: the result is a code built from the selects
// ----------------------------------------------------------------
module adcs_core_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] refSelect,
	input wire logic [2:0] muxPos,
	input wire logic [1:0] muxNeg,
	input wire logic [1:0] gainSel,
	input wire logic diffMode,
	input wire logic sampleStrobe,
	output logic [9:0] coreResult
);
	logic [1:0] refCode;
	logic [9:0] held_q;
	assign refCode = {refSelect[3] | refSelect[2], refSelect[3] | refSelect[1]};
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			held_q <= 10'h000;
		end else if (sampleStrobe) begin
			held_q <= {diffMode, muxPos, muxNeg, gainSel, refCode};
		end
	end
	assign coreResult = held_q;
endmodule

/* File: testbench/adcs_top_test.sv */
`timescale 1ns/1ps
module adcs_top_test;
	localparam logic [11:0] A_LO = {2'h0, adcs_pkg::IDX_DATA_LO, 2'h0};
	localparam logic [11:0] A_HI = {2'h0, adcs_pkg::IDX_DATA_HI, 2'h0};
	localparam logic [11:0] A_CTL = {2'h0, adcs_pkg::IDX_CTRL, 2'h0};
	localparam logic [11:0] A_TRG = {2'h0, adcs_pkg::IDX_TRIG, 2'h0};
	localparam logic [11:0] A_SEL = {2'h0, adcs_pkg::IDX_INSEL, 2'h0};
	localparam logic [1:0] OK = adcs_pkg::RESP_OKAY;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic awv = 1'b0, awr, wv = 1'b0, wr, bv, bRdy = 1'b0;
	logic arv = 1'b0, arr, rv, rRdy = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] bres, rres, mN, gS;
	logic gie = 1'b0, vack = 1'b0, dM, bgS, gdS, strb, irq;
	logic [6:0] trig = 7'h00;
	logic [9:0] res;
	logic [3:0] reference_select;
	logic [2:0] mP;
	int n_mismatch = 0, comparisons = 0;
	int cyc = 0, lastStrb = 0, strbGap = 0, strbCnt = 0;

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (strb === 1'b1) begin
			strbGap <= cyc - lastStrb;
			lastStrb <= cyc;
			strbCnt <= strbCnt + 1;
		end
	end

	adcs_top adcs_top_inst (.ref_clk(ref_clk), .resetn(resetn),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
		.s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rRdy),
		.s_axi_rdata(rd), .s_axi_rresp(rres), .globalIrqEn(gie),
		.vectorAck(vack), .trigSrc(trig), .coreResult(res),
		.refSelect(reference_select), .muxPos(mP), .muxNeg(mN), .gainSel(gS),
		.diffMode(dM), .bandgapSel(bgS), .groundSel(gdS),
		.sampleStrobe(strb), .convIrq(irq));
	adcs_core_model adcs_core_model_inst (.ref_clk(ref_clk),
		.resetn(resetn), .refSelect(reference_select), .muxPos(mP), .muxNeg(mN),
		.gainSel(gS), .diffMode(dM), .sampleStrobe(strb),
		.coreResult(res));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= {24'h0, d};
		bRdy <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awv && awr === 1'b1) awv <= 1'b0;
			if (wv && wr === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		bRdy <= 1'b0;
		chk({30'h0, bres}, {30'h0, OK});
	endtask
	task automatic rreg(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		arv <= 1'b1;
		ara <= a;
		rRdy <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arv && arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		rRdy <= 1'b0;
		d = rd;
		r = rres;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rreg(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic wait_flag();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		d = 32'h0;
		while (d[adcs_pkg::CTRL_FLAG] !== 1'b1 && n < 200) begin
			rreg(A_CTL, d, r);
			n++;
		end
		chk({31'h0, d[adcs_pkg::CTRL_FLAG]}, 32'h1);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(A_CTL, 32'h0, OK);
		rchk(A_SEL, 32'h0, OK);
		rchk(A_TRG, 32'h0, OK);
		rchk(12'h1F4, 32'h0, adcs_pkg::RESP_SLVERR);
		chk({28'h0, reference_select}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_select();
		logic [7:0] c[9] = '{8'h07, 8'h08, 8'h4A, 8'h8D, 8'h10, 8'hD7,
			8'h1D, 8'h1E, 8'h1F};
		logic [13:0] e[9] = '{14'h05C0, 14'h0604, 14'h0A08, 14'h12E4,
			14'h0610, 14'h23D0, 14'h0760, 14'h0402, 14'h0401};
		logic [13:0] m[9] = '{14'h3FC3, 14'h3FFF, 14'h3FFF, 14'h3FFF,
			14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3E03, 14'h3E03};
		for (int i = 0; i < 9; i++) begin
			wreg(A_SEL, c[i]);
			repeat (3) @(posedge ref_clk);
			chk({18'h0, {reference_select, dM, mP, mN, gS, bgS, gdS} & m[i]}, {18'h0, e[i]});
		end
		$display("test select done");
	endtask
	task automatic t_conv();
		int t0;
		wreg(A_SEL, 8'hED);
		wreg(A_CTL, 8'hC0);
		t0 = cyc;
		rchk(A_CTL, 32'hC0, OK);
		wreg(A_SEL, 8'h70);
		wait_flag();
		chk(32'(lastStrb - t0 >= 24 && lastStrb - t0 <= 32), 32'h1);
		rchk(A_LO, 32'hC0, OK);
		wreg(A_SEL, 8'h50);
		rchk(A_HI, 32'h02, OK);
		rchk(A_LO, 32'hE7, OK);
		wreg(A_CTL, 8'hD0);
		wait_flag();
		wreg(A_SEL, 8'h70);
		rchk(A_HI, 32'hB9, OK);
		wreg(A_CTL, 8'hD0);
		t0 = cyc;
		wait_flag();
		chk(32'(lastStrb - t0 >= 1 && lastStrb - t0 <= 8), 32'h1);
		rchk(A_LO, 32'h40, OK);
		rchk(A_HI, 32'h84, OK);
		$display("test conversion done");
	endtask
	task automatic t_free();
		int n, d;
		wreg(A_TRG, 8'h00);
		for (int c = 0; c < 8; c++) begin
			d = (c == 0) ? 2 : (1 << c);
			wreg(A_CTL, 8'h10);
			wreg(A_CTL, 8'hE0 | 8'(c));
			n = strbCnt;
			for (int k = 0; k < 6000 && strbCnt < n + 3; k++) @(posedge ref_clk);
			chk(32'(strbGap), 32'(13 * d));
		end
		wreg(A_CTL, 8'h10);
		n = strbCnt;
		repeat (300) @(posedge ref_clk);
		rchk(A_CTL, 32'h00, OK);
		chk(32'(strbCnt), 32'(n));
		$display("test free running done");
	endtask
	task automatic t_irq();
		gie <= 1'b1;
		wreg(A_CTL, 8'hC8);
		wait_flag();
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		gie <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		gie <= 1'b1;
		wreg(A_CTL, 8'h88);
		rchk(A_CTL, 32'h98, OK);
		chk({31'h0, irq}, 32'h1);
		@(posedge ref_clk);
		vack <= 1'b1;
		@(posedge ref_clk);
		vack <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		rchk(A_CTL, 32'h88, OK);
		$display("test interrupt done");
	endtask
	task automatic t_trig();
		int n;
		wreg(A_CTL, 8'hA0);
		for (int c = 1; c < 8; c++) begin
			wreg(A_TRG, 8'(c));
			n = strbCnt;
			trig <= 7'(1 << (c - 1));
			repeat (80) @(posedge ref_clk);
			chk(32'(strbCnt), 32'(n + 1));
			trig <= 7'h00;
			repeat (8) @(posedge ref_clk);
		end
		rchk(A_CTL, 32'hB0, OK);
		wreg(A_TRG, 8'h00);
		n = strbCnt;
		repeat (80) @(posedge ref_clk);
		chk(32'(strbCnt), 32'(n));
		$display("test trigger done");
	endtask

	initial begin
		#400us;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_select();
		t_conv();
		t_free();
		t_irq();
		t_trig();
		report_and_stop();
	end
endmodule
